/* File: pps_defines.svh */
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

// timebase
`define PPS_CLK_PERIOD_NS   25
`define PPS_TICK_NS         1000000
`define PPS_TICK_CYCLES     (`PPS_TICK_NS / `PPS_CLK_PERIOD_NS)
`define PPS_SAMPLE_MS       60
`define PPS_SAMPLE_TICKS    7'h3C

// fault delay defaults, in 1 ms ticks
`define PPS_OC_DELAY_RST    16'h000C
`define PPS_OV_DELAY_RST    16'h03B6
`define PPS_UV_DELAY_RST    16'h03B6

// register byte offsets
`define PPS_REG_OC_DELAY    4'h0
`define PPS_REG_OV_DELAY    4'h4
`define PPS_REG_UV_DELAY    4'h8
`define PPS_REG_STATUS      4'hC

// status fields
`define PPS_ST_ACTIVE       0
`define PPS_ST_OV_LATCHED   1
`define PPS_ST_OC_TRIP      2
`define PPS_ST_PACK_DIS     3
`define PPS_ST_CHG_DET      4
`define PPS_ST_UV_SAMPLED   5
`define PPS_ST_OV_COND      6
`define PPS_ST_OC_COND      7

// timer indices
`define PPS_T_OC            0
`define PPS_T_OV            1
`define PPS_T_UV            2

`endif

/* File: pps_pkg.sv */
package pps_pkg;

  typedef enum logic
  {
    PPS_SLEEP  = 1'b0,
    PPS_ACTIVE = 1'b1
  } pps_state_t;

  // comparator results from the analog front end, one bit per cell where paired
  typedef struct packed
  {
    logic [1:0] cell_over;
    logic [1:0] cell_under;
    logic [1:0] cell_below_ce;
    logic       terminal_float;
    logic       low_side_oc;
    logic       high_side_oc;
    logic       low_side_cd;
    logic       high_side_cd;
    logic       pack_disable_in;
  } pps_cmp_t;

  typedef struct packed
  {
    logic [1:0] over;
    logic [1:0] under;
    logic [1:0] below_ce;
  } pps_sample_t;

endpackage

/* File: pps_protect.sv */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "pps_defines.svh"

module pps_protect
  import pps_pkg::*;
#(
  parameter int TICK_CYCLES = `PPS_TICK_CYCLES
)
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire pps_cmp_t    cmp_in,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             charge_gate_out,
  output logic             charge_gate_oe,
  output logic             discharge_gate_out
);

  localparam int CMP_W = $bits(pps_cmp_t);

  // two-flop synchroniser; comparators are asynchronous to core_clk
  logic [CMP_W-1:0] sync1_reg;
  logic [CMP_W-1:0] sync2_reg;
  pps_cmp_t         cmp;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= cmp_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign cmp = pps_cmp_t'(sync2_reg);

  // 1 ms tick and 60 ms sampling instant
  logic [31:0] tick_cnt_reg;
  logic [6:0]  samp_cnt_reg;
  logic        ms_tick;
  logic        sample_tick;

  assign ms_tick     = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
  assign sample_tick = ms_tick && (samp_cnt_reg == `PPS_SAMPLE_TICKS - 7'h01);

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      tick_cnt_reg <= 32'h0;
      samp_cnt_reg <= 7'h00;
    end
    else
    begin
      tick_cnt_reg <= ms_tick ? 32'h0 : tick_cnt_reg + 32'h1;
      if (sample_tick)
        samp_cnt_reg <= 7'h00;
      else if (ms_tick)
        samp_cnt_reg <= samp_cnt_reg + 7'h01;
    end
  end

  // cell comparisons are only taken at the sampling instant
  pps_sample_t samp_reg;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      samp_reg <= '0;
    else if (sample_tick)
      samp_reg <= '{over: cmp.cell_over, under: cmp.cell_under, below_ce: cmp.cell_below_ce};
  end

  // fault conditions
  logic pack_dis;
  logic chg_det;
  logic oc_cond;
  logic ov_cond;
  logic uv_cond;
  logic ce_all;

  assign pack_dis = cmp.pack_disable_in;
  assign chg_det  = cmp.low_side_cd | cmp.high_side_cd;
  assign oc_cond  = cmp.low_side_oc | cmp.high_side_oc;
  assign ov_cond  = (|samp_reg.over) | cmp.terminal_float;
  assign uv_cond  = |samp_reg.under;
  assign ce_all   = &samp_reg.below_ce;

  // software-set delays, one per fault
  logic [15:0] oc_delay_reg;
  logic [15:0] ov_delay_reg;
  logic [15:0] uv_delay_reg;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      oc_delay_reg <= `PPS_OC_DELAY_RST;
      ov_delay_reg <= `PPS_OV_DELAY_RST;
      uv_delay_reg <= `PPS_UV_DELAY_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `PPS_REG_OC_DELAY)
        oc_delay_reg <= reg_wdata[15:0];
      if (reg_addr == `PPS_REG_OV_DELAY)
        ov_delay_reg <= reg_wdata[15:0];
      if (reg_addr == `PPS_REG_UV_DELAY)
        uv_delay_reg <= reg_wdata[15:0];
    end
  end

  pps_state_t state_reg;
  logic       ov_latched_reg;
  logic       oc_trip_reg;

  // three persistence timers, alike except for their hold conditions
  logic [2:0]  t_cond;
  logic [2:0]  t_hold;
  logic [2:0]  t_exp;
  logic [15:0] t_dly [3];
  logic [15:0] t_cnt_reg [3];

  assign t_cond[`PPS_T_OC] = oc_cond;
  assign t_cond[`PPS_T_OV] = ov_cond;
  assign t_cond[`PPS_T_UV] = uv_cond;
  assign t_hold[`PPS_T_OC] = pack_dis || state_reg == PPS_SLEEP;
  assign t_hold[`PPS_T_OV] = 1'b0;
  assign t_hold[`PPS_T_UV] = state_reg == PPS_SLEEP;
  assign t_dly[`PPS_T_OC]  = oc_delay_reg;
  assign t_dly[`PPS_T_OV]  = ov_delay_reg;
  assign t_dly[`PPS_T_UV]  = uv_delay_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_tmr
      assign t_exp[gi] = t_cond[gi] && !t_hold[gi] && (t_cnt_reg[gi] >= t_dly[gi]);

      always_ff @(posedge core_clk)
      begin
        if (!resetn)
          t_cnt_reg[gi] <= 16'h0000;
        else if (!t_cond[gi] || t_hold[gi])
          t_cnt_reg[gi] <= 16'h0000;
        else if (ms_tick && t_cnt_reg[gi] != 16'hFFFF)
          t_cnt_reg[gi] <= t_cnt_reg[gi] + 16'h0001;
      end

      // a fault that clears early must restart its timer from zero
      property p_restart;
        @(posedge core_clk) disable iff (!resetn)
        !t_cond[gi] |=> t_cnt_reg[gi] == 16'h0000;
      endproperty
      a_restart: assert property (p_restart)
        else $error("fault timer kept counting after its condition cleared");
    end
  endgenerate

  // sleep/active, latched overvoltage and overcurrent trip
  pps_state_t state_next;
  logic       ov_latched_next;
  logic       oc_trip_next;

  assign state_next = (state_reg == PPS_SLEEP) ? (chg_det ? PPS_ACTIVE : PPS_SLEEP)
                    : (t_exp[`PPS_T_UV] ? PPS_SLEEP : PPS_ACTIVE);
  // set wins over clear on the same edge
  assign ov_latched_next = t_exp[`PPS_T_OV] | (ov_latched_reg & ~(ce_all & ~ov_cond));
  assign oc_trip_next    = t_exp[`PPS_T_OC] | (oc_trip_reg & oc_cond);

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_reg      <= PPS_SLEEP;
      ov_latched_reg <= 1'b0;
      oc_trip_reg    <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      ov_latched_reg <= ov_latched_next;
      oc_trip_reg    <= oc_trip_next;
    end
  end

  // gate drive; the charge pin is released, never pulled high, when blocking
  logic chg_permit_next;
  logic dsg_permit_next;

  assign chg_permit_next = !(ov_latched_reg || pack_dis);
  assign dsg_permit_next = state_reg == PPS_ACTIVE && !oc_trip_reg && !pack_dis;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      charge_gate_out    <= 1'b0;
      charge_gate_oe     <= 1'b0;
      discharge_gate_out <= 1'b0;
    end
    else
    begin
      charge_gate_out    <= chg_permit_next;
      charge_gate_oe     <= chg_permit_next;
      discharge_gate_out <= dsg_permit_next;
    end
  end

  // register read port, data one cycle after the strobe
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign status_word = {24'h0, oc_cond, ov_cond, uv_cond, chg_det, pack_dis,
                        oc_trip_reg, ov_latched_reg, state_reg == PPS_ACTIVE};

  assign rd_mux = (reg_addr == `PPS_REG_OC_DELAY) ? {16'h0, oc_delay_reg}
                : (reg_addr == `PPS_REG_OV_DELAY) ? {16'h0, ov_delay_reg}
                : (reg_addr == `PPS_REG_UV_DELAY) ? {16'h0, uv_delay_reg}
                : (reg_addr == `PPS_REG_STATUS)   ? status_word
                : 32'h0;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  property p_sample_only;
    @(posedge core_clk) disable iff (!resetn)
    !sample_tick |=> $stable(samp_reg);
  endproperty
  a_sample_only: assert property (p_sample_only)
    else $error("cell sample changed outside the sampling instant");

  property p_powerup_sleep;
    @(posedge core_clk)
    !resetn |=> state_reg == PPS_SLEEP && !discharge_gate_out;
  endproperty
  a_powerup_sleep: assert property (p_powerup_sleep)
    else $error("not asleep with discharge low after reset");

  property p_sleep_dsg_low;
    @(posedge core_clk) disable iff (!resetn)
    state_reg == PPS_SLEEP |=> !discharge_gate_out;
  endproperty
  a_sleep_dsg_low: assert property (p_sleep_dsg_low)
    else $error("discharge gate high while asleep");

  property p_wake;
    @(posedge core_clk) disable iff (!resetn)
    state_reg == PPS_SLEEP && chg_det && !pack_dis ##1 !pack_dis && !oc_trip_reg
      |=> discharge_gate_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("charge detect did not enable discharge gate");

  property p_uv_sleep;
    @(posedge core_clk) disable iff (!resetn)
    t_exp[`PPS_T_UV] |=> state_reg == PPS_SLEEP ##1 !discharge_gate_out;
  endproperty
  a_uv_sleep: assert property (p_uv_sleep)
    else $error("undervoltage expiry did not force sleep");

  property p_ov_release;
    @(posedge core_clk) disable iff (!resetn)
    t_exp[`PPS_T_OV] |=> ##1 !charge_gate_oe;
  endproperty
  a_ov_release: assert property (p_ov_release)
    else $error("charge gate not released after overvoltage expiry");

  property p_ov_hold;
    @(posedge core_clk) disable iff (!resetn)
    ov_latched_reg && !ce_all |=> ov_latched_reg;
  endproperty
  a_ov_hold: assert property (p_ov_hold)
    else $error("charging re-enabled before all cells below enable level");

  property p_oc_hold;
    @(posedge core_clk) disable iff (!resetn)
    oc_trip_reg && oc_cond |=> oc_trip_reg ##1 !discharge_gate_out;
  endproperty
  a_oc_hold: assert property (p_oc_hold)
    else $error("overcurrent trip cleared while a comparison still true");

  property p_disable_gates;
    @(posedge core_clk) disable iff (!resetn)
    pack_dis |=> !discharge_gate_out && !charge_gate_oe;
  endproperty
  a_disable_gates: assert property (p_disable_gates)
    else $error("gate active while pack disabled");

  property p_oc_timer_reset;
    @(posedge core_clk) disable iff (!resetn)
    pack_dis |=> t_cnt_reg[`PPS_T_OC] == 16'h0000;
  endproperty
  a_oc_timer_reset: assert property (p_oc_timer_reset)
    else $error("overcurrent timer ran during pack disable");

endmodule

/* File: pps_cell_model.sv */
`timescale 1ns/1ps
// cells, sense resistors and charge fet gate with its pulldown
module pps_cell_model
  import pps_pkg::*;
#(
  parameter int OV_MV = 4250,
  parameter int UV_MV = 2250
)
(
  input  wire logic [12:0]       cell1_mv,
  input  wire logic [12:0]       cell2_mv,
  input  wire logic signed [9:0] low_mv,
  input  wire logic signed [9:0] high_mv,
  input  wire logic              term_float,
  input  wire logic              pack_dis,
  input  wire logic              chg_out,
  input  wire logic              chg_oe,
  output pps_cmp_t               cmp,
  output logic                   chg_wire
);
  localparam int CE_MV = OV_MV - 150;
  assign cmp.cell_over       = {cell2_mv > OV_MV, cell1_mv > OV_MV};
  assign cmp.cell_under      = {cell2_mv < UV_MV, cell1_mv < UV_MV};
  assign cmp.cell_below_ce   = {cell2_mv < CE_MV, cell1_mv < CE_MV};
  assign cmp.terminal_float  = term_float;
  // low sense is csl minus cell2 negative, high sense is csh minus cell1 positive
  assign cmp.low_side_oc     = low_mv > 10'sh0A0;
  assign cmp.high_side_oc    = high_mv < -10'sh0A0;
  assign cmp.low_side_cd     = low_mv < -10'sh046;
  assign cmp.high_side_cd    = high_mv > 10'sh046;
  assign cmp.pack_disable_in = pack_dis;
  // released pin is pulled low externally, which blocks charging
  assign chg_wire = chg_oe ? chg_out : 1'b0;
endmodule

/* File: two_cell_pack_protection_fsm_test.sv */
`timescale 1ns/1ps
module two_cell_pack_protection_fsm_test;
  import pps_pkg::*;
  logic              core_clk;
  logic              resetn;
  logic              reg_wr;
  logic              reg_rd;
  logic              rd_d = 1'b0;
  logic [3:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic [31:0]       reg_rdata;
  logic [12:0]       cell1_mv;
  logic [12:0]       cell2_mv;
  logic signed [9:0] low_mv;
  logic signed [9:0] high_mv;
  logic              term_float;
  logic              pack_dis;
  logic              chg_out;
  logic              chg_oe;
  logic              dsg_out;
  logic              chg_wire;
  pps_cmp_t          cmp;
  logic [31:0]       notes[$];
  int                fails;
  int                comparisons;

  pps_protect #(.TICK_CYCLES(4)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .cmp_in(cmp), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .charge_gate_out(chg_out), .charge_gate_oe(chg_oe), .discharge_gate_out(dsg_out));

  pps_cell_model u_cells (
    .cell1_mv(cell1_mv), .cell2_mv(cell2_mv), .low_mv(low_mv), .high_mv(high_mv),
    .term_float(term_float), .pack_dis(pack_dis), .chg_out(chg_out), .chg_oe(chg_oe),
    .cmp(cmp), .chg_wire(chg_wire));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(logic [3:0] a, logic [31:0] exp);
    notes.push_back(exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask

  // bounded wait until the masked {charge wire, discharge} pair matches
  task automatic waitg(logic [1:0] m, logic [1:0] e, int n);
    int i;
    for (i = 0; i < n && ({chg_wire, dsg_out} & m) !== e; i++)
      @(posedge core_clk);
    check("gates", 32'(e), 32'({chg_wire, dsg_out} & m));
  endtask

  // the masked pair must hold its value for n cycles
  task automatic stay(logic [1:0] m, logic [1:0] e, int n);
    logic [1:0] bad;
    bad = 2'h0;
    repeat (n)
    begin
      @(posedge core_clk);
      bad |= ({chg_wire, dsg_out} & m) ^ e;
    end
    check("gates held", 32'h0, 32'(bad));
  endtask

  always @(posedge core_clk)
  begin
    if (rd_d)
      check("reg_rdata", notes.pop_front(), reg_rdata);
    rd_d <= reg_rd;
  end

  initial
  begin
    #(25 * 20000);
    fails++;
    results();
  end

  initial
  begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    cell1_mv = 13'hC80;
    cell2_mv = 13'hC80;
    low_mv = 10'sh000;
    high_mv = 10'sh000;
    term_float = 1'b0;
    pack_dis = 1'b0;
    void'($urandom(32'h125C5152));
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    cell1_mv <= 13'(3000 + $urandom % 1000);
    cell2_mv <= 13'(3000 + $urandom % 1000);
    rd(4'h0, 32'h0000000C);
    rd(4'h4, 32'h000003B6);
    rd(4'h8, 32'h000003B6);
    rd(4'h2, 32'h0);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, 32'h0);
    wr(4'h0, {16'($urandom), 16'h0004});
    wr(4'h4, {16'($urandom), 16'h0002});
    wr(4'h8, {16'($urandom), 16'h0003});
    rd(4'h0, 32'h4);
    rd(4'h4, 32'h2);
    rd(4'h8, 32'h3);
    stay(2'b01, 2'b00, 300);
    low_mv <= -10'sh064;
    waitg(2'b11, 2'b11, 8);
    rd(4'hC, 32'h00000011);
    low_mv <= 10'sh000;
    stay(2'b11, 2'b11, 4);
    rd(4'hC, 32'h1);
    // overcurrent shorter than the delay must not trip
    low_mv <= 10'sh0B4;
    stay(2'b01, 2'b01, 10);
    low_mv <= 10'sh000;
    stay(2'b01, 2'b01, 30);
    high_mv <= -10'sh0B4;
    waitg(2'b01, 2'b00, 40);
    rd(4'hC, 32'h00000085);
    high_mv <= 10'sh000;
    waitg(2'b01, 2'b01, 10);
    pack_dis <= 1'b1;
    waitg(2'b11, 2'b00, 6);
    low_mv <= 10'sh0B4;
    stay(2'b11, 2'b00, 60);
    rd(4'hC, 32'h00000089);
    pack_dis <= 1'b0;
    waitg(2'b11, 2'b11, 6);
    waitg(2'b01, 2'b00, 30);
    low_mv <= 10'sh000;
    waitg(2'b01, 2'b01, 10);
    cell1_mv <= 13'h10CC;
    waitg(2'b11, 2'b01, 260);
    rd(4'hC, 32'h00000043);
    cell1_mv <= 13'h1068;
    stay(2'b10, 2'b00, 300);
    cell1_mv <= 13'hFA0;
    waitg(2'b11, 2'b11, 260);
    term_float <= 1'b1;
    waitg(2'b10, 2'b00, 260);
    term_float <= 1'b0;
    waitg(2'b10, 2'b10, 260);
    cell2_mv <= 13'h7D0;
    waitg(2'b01, 2'b00, 260);
    rd(4'hC, 32'h00000020);
    cell2_mv <= 13'hE10;
    stay(2'b01, 2'b00, 300);
    rd(4'hC, 32'h0);
    high_mv <= 10'sh064;
    waitg(2'b01, 2'b01, 8);
    high_mv <= 10'sh000;
    repeat (4) @(posedge core_clk);
    results();
  end
endmodule
